// ===== rtl/irq_pkg.sv
// Constants shared by the interrupt enable and flag logic
package irq_pkg;
  // Register offsets on the plain register port
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_ENABLE_ONE = 8'h01;
  localparam logic [7:0] ADDR_ENABLE_TWO = 8'h02;
  localparam logic [7:0] ADDR_EVENT_STATUS = 8'h03;
  localparam logic [7:0] ADDR_EVENT_MASK = 8'h04;
  localparam logic [7:0] ADDR_CORE_STATE = 8'h05;

  // Control register field positions
  localparam int CTL_GLOBAL_EN = 7;
  localparam int CTL_PERIPH_EN = 6;
  localparam int CTL_TIMER_ZERO_EN = 5;
  localparam int CTL_EXT_PIN_EN = 4;
  localparam int CTL_PIN_CHANGE_EN = 3;
  localparam int CTL_TIMER_ZERO_FLAG = 2;
  localparam int CTL_EXT_PIN_FLAG = 1;
  localparam int CTL_PIN_CHANGE_FLAG = 0;

  // Reset values and implemented-bit masks
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] CONTROL_WRITABLE = 8'hfe;
  localparam logic [7:0] ENABLE_ONE_IMPL = 8'hff;
  localparam logic [7:0] ENABLE_TWO_IMPL = 8'hef;

  // Event status bits and their mask
  localparam int EV_TAKEN = 0;
  localparam int EV_RETURN = 1;
  localparam int EV_SPURIOUS = 2;
  localparam int EV_WIDTH = 3;
  localparam logic [2:0] EVENT_RESET = 3'h0;

  // Vector address loaded into the program counter on entry
  localparam logic [14:0] VECTOR_ADDR = 15'h0004;
  localparam logic [14:0] VECTOR_RESET = 15'h0000;

  // Core sequencing state as seen by this block
  typedef enum logic {CORE_RUN, CORE_SERVICE} core_state_t;
endpackage

// ===== rtl/edge_evt_if.sv
// Edge event carrier between the pin front end and the flag logic
`timescale 1ns/1ps
interface edge_evt_if;
  logic edge_select;
  logic edge_pulse;
  modport detector (input edge_select, output edge_pulse);
  modport consumer (output edge_select, input edge_pulse);
endinterface

// ===== rtl/ext_pin_edge.sv
// External pin synchroniser and edge detector
`timescale 1ns/1ps
module ext_pin_edge (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ext_pin,
  edge_evt_if.detector evt
);
  logic sync_a;
  logic sync_b;
  logic pin_prev;
  logic next_sync_a;
  logic next_sync_b;
  logic next_pin_prev;
  logic next_pulse;
  logic pulse;

  // Two-stage synchroniser; only the second stage feeds the detector
  always_comb begin
    next_sync_a = ext_pin;
    next_sync_b = sync_a;
    next_pin_prev = sync_b;
    // Rising edge when select is high, falling edge otherwise
    if (evt.edge_select) begin
      next_pulse = sync_b & ~pin_prev;
    end else begin
      next_pulse = ~sync_b & pin_prev;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      pin_prev <= 1'b0;
      pulse <= 1'b0;
    end else begin
      sync_a <= next_sync_a;
      sync_b <= next_sync_b;
      pin_prev <= next_pin_prev;
      pulse <= next_pulse;
    end
  end

  assign evt.edge_pulse = pulse;
endmodule

// ===== rtl/irq_enable_flag_logic.sv
// Interrupt enable and flag gating with request toward the core
//
// How it works
// - Global enable bit 7 lets enabled sources request; cleared blocks all.
// - Peripheral enable bit 6 gates every source in the enable registers.
// - Flags set on their events whatever the enables say.
// - Timer zero overflow sets flag bit 2; enable bit 5, core level.
// - Valid external pin edge sets flag bit 1; enable bit 4.
// - Pin-change summary bit 0 reads one while any pin-change flag is set.
// - Summary bit is read-only; clears when all pin-change flags clear.
// - Pin-change enable bit 3 passes or blocks the summary flag.
// - First enable register holds eight peripheral enables, bit 7 to 0.
// - Second enable register holds seven enables at bits 7-5 and 3-0.
// - Second enable register bit 4 reads zero and ignores writes.
// - All implemented control and enable bits reset to zero.
// - Accepted request clears global enable and loads vector 0004h.
// - Return operation sets global enable again.
// - Edge select picks rising edge when set, falling when clear.
//
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/1ps
module irq_enable_flag_logic (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic timer_zero_ovf,
  input wire logic ext_pin,
  input wire logic ext_pin_edge_select,
  input wire logic pin_change_any,
  input wire logic [7:0] periph_flags_one,
  input wire logic [7:0] periph_flags_two,
  input wire logic irq_accept,
  input wire logic return_from_irq_op,
  output logic irq_request,
  output logic vector_load,
  output logic [14:0] vector_addr,
  output logic event_irq
);
  // Architectural registers
  logic [7:0] interrupt_control;
  logic [7:0] peripheral_irq_enable_one;
  logic [7:0] peripheral_irq_enable_two;
  logic [2:0] event_status;
  logic [2:0] event_mask;
  irq_pkg::core_state_t core_state;
  logic [7:0] rdata;
  logic load_pulse;
  logic [14:0] vector;

  // Next values
  logic [7:0] next_interrupt_control;
  logic [7:0] next_peripheral_irq_enable_one;
  logic [7:0] next_peripheral_irq_enable_two;
  logic [2:0] next_event_status;
  logic [2:0] next_event_mask;
  irq_pkg::core_state_t next_core_state;
  logic [7:0] next_rdata;
  logic next_load_pulse;
  logic [14:0] next_vector;

  // Decoded strobes and gating terms
  logic wr_control;
  logic wr_enable_one;
  logic wr_enable_two;
  logic wr_event_status;
  logic wr_event_mask;
  logic ext_edge;
  logic core_pending;
  logic periph_pending;
  logic take;
  logic spurious;
  logic [7:0] control_view;
  logic [7:0] periph_hits_one;
  logic [7:0] periph_hits_two;

  edge_evt_if edge_bus ();

  // External pin front end runs in this clock after a synchroniser
  ext_pin_edge u_ext_pin_edge (
    .ref_clk(ref_clk),
    .rst(rst),
    .ext_pin(ext_pin),
    .evt(edge_bus.detector)
  );

  // Edge select comes from logic on this clock, so no synchroniser
  assign edge_bus.edge_select = ext_pin_edge_select;
  assign ext_edge = edge_bus.edge_pulse;

  // Address decode for writes
  always_comb begin
    wr_control = 1'b0;
    wr_enable_one = 1'b0;
    wr_enable_two = 1'b0;
    wr_event_status = 1'b0;
    wr_event_mask = 1'b0;
    if (!reg_wr) begin
      wr_control = 1'b0;
    end else if (reg_addr == irq_pkg::ADDR_CONTROL) begin
      wr_control = 1'b1;
    end else if (reg_addr == irq_pkg::ADDR_ENABLE_ONE) begin
      wr_enable_one = 1'b1;
    end else if (reg_addr == irq_pkg::ADDR_ENABLE_TWO) begin
      wr_enable_two = 1'b1;
    end else if (reg_addr == irq_pkg::ADDR_EVENT_STATUS) begin
      wr_event_status = 1'b1;
    end else if (reg_addr == irq_pkg::ADDR_EVENT_MASK) begin
      wr_event_mask = 1'b1;
    end
  end

  // Per-source flag and enable pairs of both peripheral registers
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_pairs
      assign periph_hits_one[i] = periph_flags_one[i] &
        peripheral_irq_enable_one[i];
      assign periph_hits_two[i] = periph_flags_two[i] &
        peripheral_irq_enable_two[i];
    end
  endgenerate

  // Core-level sources are not subject to the peripheral enable
  always_comb begin
    core_pending =
      (interrupt_control[irq_pkg::CTL_TIMER_ZERO_EN] &
       interrupt_control[irq_pkg::CTL_TIMER_ZERO_FLAG]) |
      (interrupt_control[irq_pkg::CTL_EXT_PIN_EN] &
       interrupt_control[irq_pkg::CTL_EXT_PIN_FLAG]) |
      (interrupt_control[irq_pkg::CTL_PIN_CHANGE_EN] &
       pin_change_any);
    periph_pending = interrupt_control[irq_pkg::CTL_PERIPH_EN] &
      ((|periph_hits_one) | (|periph_hits_two));
  end

  // Single request line; a stale flag fires as soon as it is enabled
  assign irq_request = interrupt_control[irq_pkg::CTL_GLOBAL_EN] &
    (core_pending | periph_pending);

  // Accept only counts while a request stands, which implies global enable
  assign take = irq_accept & irq_request;
  assign spurious = irq_accept & ~irq_request;

  // Control register: hardware sets win over a firmware clear
  always_comb begin
    next_interrupt_control = interrupt_control;
    if (wr_control) begin
      next_interrupt_control = reg_wdata & irq_pkg::CONTROL_WRITABLE;
    end
    if (timer_zero_ovf) begin
      next_interrupt_control[irq_pkg::CTL_TIMER_ZERO_FLAG] = 1'b1;
    end
    if (ext_edge) begin
      next_interrupt_control[irq_pkg::CTL_EXT_PIN_FLAG] = 1'b1;
    end
    // Return re-arms; an accept in the same cycle wins and disarms
    if (return_from_irq_op) begin
      next_interrupt_control[irq_pkg::CTL_GLOBAL_EN] = 1'b1;
    end
    if (take) begin
      next_interrupt_control[irq_pkg::CTL_GLOBAL_EN] = 1'b0;
    end
  end

  // Enable registers; unimplemented bit stays zero
  always_comb begin
    next_peripheral_irq_enable_one = peripheral_irq_enable_one;
    next_peripheral_irq_enable_two = peripheral_irq_enable_two;
    if (wr_enable_one) begin
      next_peripheral_irq_enable_one =
        reg_wdata & irq_pkg::ENABLE_ONE_IMPL;
    end
    if (wr_enable_two) begin
      next_peripheral_irq_enable_two =
        reg_wdata & irq_pkg::ENABLE_TWO_IMPL;
    end
  end

  // Sticky event status, write one to clear; new events win the cycle
  always_comb begin
    next_event_status = event_status;
    next_event_mask = event_mask;
    if (wr_event_status) begin
      next_event_status = event_status & ~reg_wdata[2:0];
    end
    if (wr_event_mask) begin
      next_event_mask = reg_wdata[2:0];
    end
    if (take) begin
      next_event_status[irq_pkg::EV_TAKEN] = 1'b1;
    end
    if (return_from_irq_op) begin
      next_event_status[irq_pkg::EV_RETURN] = 1'b1;
    end
    if (spurious) begin
      next_event_status[irq_pkg::EV_SPURIOUS] = 1'b1;
    end
  end

  assign event_irq = |(event_status & event_mask);

  // Tracks whether the core is inside a handler
  always_comb begin
    next_core_state = core_state;
    case (core_state)
      irq_pkg::CORE_RUN: begin
        if (take) begin
          next_core_state = irq_pkg::CORE_SERVICE;
        end
      end
      irq_pkg::CORE_SERVICE: begin
        if (return_from_irq_op && !take) begin
          next_core_state = irq_pkg::CORE_RUN;
        end
      end
      default: begin
        next_core_state = irq_pkg::CORE_RUN;
      end
    endcase
  end

  // Vector load strobe and address toward the program counter
  always_comb begin
    next_load_pulse = take;
    next_vector = vector;
    if (take) begin
      next_vector = irq_pkg::VECTOR_ADDR;
    end
  end

  assign vector_load = load_pulse;
  assign vector_addr = vector;

  // Summary flag is live from the pin-change flags, never stored here
  always_comb begin
    control_view = interrupt_control;
    control_view[irq_pkg::CTL_PIN_CHANGE_FLAG] = pin_change_any;
  end

  // Read mux; data stand only in the cycle after the strobe
  always_comb begin
    next_rdata = 8'h00;
    if (!reg_rd) begin
      next_rdata = 8'h00;
    end else if (reg_addr == irq_pkg::ADDR_CONTROL) begin
      next_rdata = control_view;
    end else if (reg_addr == irq_pkg::ADDR_ENABLE_ONE) begin
      next_rdata = peripheral_irq_enable_one;
    end else if (reg_addr == irq_pkg::ADDR_ENABLE_TWO) begin
      next_rdata = peripheral_irq_enable_two;
    end else if (reg_addr == irq_pkg::ADDR_EVENT_STATUS) begin
      next_rdata = {5'h00, event_status};
    end else if (reg_addr == irq_pkg::ADDR_EVENT_MASK) begin
      next_rdata = {5'h00, event_mask};
    end else if (reg_addr == irq_pkg::ADDR_CORE_STATE) begin
      next_rdata = {7'h00, core_state == irq_pkg::CORE_SERVICE};
    end
  end

  assign reg_rdata = rdata;

  // Control register; every reset kind clears it, so requests start off
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      interrupt_control <= irq_pkg::CONTROL_RESET;
    end else begin
      interrupt_control <= next_interrupt_control;
    end
  end

  // Enable registers share the reset of the control register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      peripheral_irq_enable_one <= irq_pkg::ENABLE_RESET;
      peripheral_irq_enable_two <= irq_pkg::ENABLE_RESET;
    end else begin
      peripheral_irq_enable_one <= next_peripheral_irq_enable_one;
      peripheral_irq_enable_two <= next_peripheral_irq_enable_two;
    end
  end

  // Event status and its mask
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      event_status <= irq_pkg::EVENT_RESET;
      event_mask <= irq_pkg::EVENT_RESET;
    end else begin
      event_status <= next_event_status;
      event_mask <= next_event_mask;
    end
  end

  // Handler tracking; a reset leaves the core outside any handler
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      core_state <= irq_pkg::CORE_RUN;
    end else begin
      core_state <= next_core_state;
    end
  end

  // Vector strobe and address toward the program counter
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      load_pulse <= 1'b0;
      vector <= irq_pkg::VECTOR_RESET;
    end else begin
      load_pulse <= next_load_pulse;
      vector <= next_vector;
    end
  end

  // Read data register; cleared so nothing stale shows after reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= next_rdata;
    end
  end
endmodule

// ===== bench/irq_enable_flag_logic_asserts.sv
// Port-level checks for the interrupt enable and flag logic
`timescale 1ns/1ps
module irq_enable_flag_logic_asserts (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic pin_change_any,
  input wire logic irq_accept,
  input wire logic irq_request,
  input wire logic vector_load,
  input wire logic [14:0] vector_addr
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // A take is an accept met by a live request
  sequence s_take;
    irq_accept && irq_request;
  endsequence
  sequence s_load_pulse;
    vector_load ##1 !vector_load;
  endsequence
  AST_TAKE_LOADS: assert property (s_take |=> s_load_pulse)
    else $error("take without a single vector load");
  AST_NO_STRAY_LOAD: assert property (
    !(irq_accept && irq_request) |=> !vector_load)
    else $error("vector load without a take");
  AST_VECTOR_ADDR: assert property (
    vector_load |=> vector_addr == 15'h0004)
    else $error("wrong vector address");
  AST_TAKE_DROPS_REQ: assert property (s_take |=> !irq_request)
    else $error("request stayed up after a take");
  AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
  AST_UNMAPPED_ZERO: assert property (
    reg_rd && reg_addr > 8'h05 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_BIT4_ZERO: assert property (
    reg_rd && reg_addr == irq_pkg::ADDR_ENABLE_TWO |=> !reg_rdata[4])
    else $error("enable two bit 4 not zero");
  AST_SUMMARY_LIVE: assert property (
    reg_rd && reg_addr == irq_pkg::ADDR_CONTROL
    |=> reg_rdata[0] == $past(pin_change_any))
    else $error("summary flag not live");
endmodule

bind irq_enable_flag_logic irq_enable_flag_logic_asserts chk (
  .ref_clk, .rst, .reg_addr, .reg_rd, .reg_rdata, .pin_change_any,
  .irq_accept, .irq_request, .vector_load, .vector_addr);

// ===== bench/core_model.sv
// Behavioural core sequencer that takes requests and returns
`timescale 1ns/1ps
module core_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic irq_request,
  input wire logic take_en,
  input wire logic slow,
  input wire logic ret_cmd,
  input wire logic stray,
  output logic irq_accept,
  output logic return_from_irq_op
);
  int wait_cnt;
  // Slow mode stalls three cycles before taking
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq_accept <= 1'h0;
      return_from_irq_op <= 1'h0;
      wait_cnt <= 0;
    end else begin
      return_from_irq_op <= ret_cmd;
      irq_accept <= 1'h0;
      if (take_en && irq_request && !irq_accept) begin
        if (slow && wait_cnt < 3) begin
          wait_cnt <= wait_cnt + 1;
        end else begin
          irq_accept <= 1'h1;
          wait_cnt <= 0;
        end
      end
      // Stray accept with nothing pending, to reach the spurious event
      if (stray) begin
        irq_accept <= 1'h1;
      end
    end
  end
endmodule

// ===== bench/irq_enable_flag_logic_tb_top.sv
// Self-checking bench for the interrupt enable and flag logic
`timescale 1ns/1ps
module irq_enable_flag_logic_tb_top;
  logic ref_clk = 1'h0;
  logic rst = 1'h1;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] periph_flags_one = 8'h00;
  logic [7:0] periph_flags_two = 8'h00;
  logic timer_zero_ovf = 1'h0;
  logic ext_pin = 1'h0;
  logic ext_pin_edge_select = 1'h0;
  logic pin_change_any = 1'h0;
  logic take_en = 1'h0;
  logic slow = 1'h0;
  logic ret_cmd = 1'h0;
  logic stray = 1'h0;
  logic [7:0] reg_rdata;
  logic [14:0] vector_addr;
  logic irq_accept, return_from_irq_op, irq_request, vector_load, event_irq;
  int fail_count = 0;
  int checks = 0;
  int ctl = 0;
  int en1 = 0;
  int en2 = 0;

  irq_enable_flag_logic dut (.ref_clk, .rst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .timer_zero_ovf, .ext_pin,
    .ext_pin_edge_select, .pin_change_any, .periph_flags_one,
    .periph_flags_two, .irq_accept, .return_from_irq_op, .irq_request,
    .vector_load, .vector_addr, .event_irq);
  core_model core (.ref_clk, .rst, .irq_request, .take_en, .slow,
    .ret_cmd, .stray, .irq_accept, .return_from_irq_op);

  always #20 ref_clk = ~ref_clk;

  task automatic cmp(string n, logic [7:0] e, logic [7:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge ref_clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rchk(string n, logic [7:0] a, logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge ref_clk);
    reg_rd <= 1'h0;
    #1;
    cmp(n, e, reg_rdata);
  endtask
  // Summary bit reads the live pin-change input, never written
  function automatic logic [7:0] ctl_exp();
    return (8'(ctl) & 8'hfe) | {7'h00, pin_change_any};
  endfunction
  function automatic logic exp_req();
    logic [7:0] c;
    logic core_hit, per_hit;
    c = 8'(ctl);
    core_hit = c[5] & c[2] | c[4] & c[1] | c[3] & pin_change_any;
    per_hit = c[6] & |(8'(en1) & periph_flags_one
      | 8'(en2) & periph_flags_two);
    return c[7] & (core_hit | per_hit);
  endfunction
  task automatic stop_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    stop_test();
  end

  initial begin
    int n;
    int v;
    void'($urandom(32'h3adf0836));
    repeat (6) @(posedge ref_clk);
    rst <= 1'h0;
    rchk("control", 8'h00, 8'h00);
    rchk("enable_one", 8'h01, 8'h00);
    rchk("enable_two", 8'h02, 8'h00);
    rchk("unmapped", 8'h07, 8'h00);
    // Random enables, flags and control; request follows the gating
    repeat (40) begin
      en1 = $urandom & 255;
      en2 = $urandom & 255;
      v = $urandom & 255;
      wr(8'h01, 8'(en1));
      wr(8'h02, 8'(en2));
      wr(8'h00, 8'(v));
      ctl = v & 254;
      en2 = en2 & 8'hef;
      periph_flags_one <= 8'($urandom);
      periph_flags_two <= 8'($urandom);
      pin_change_any <= 1'($urandom);
      rchk("enable_one", 8'h01, 8'(en1));
      rchk("enable_two", 8'h02, 8'(en2));
      rchk("control", 8'h00, ctl_exp());
      cmp("request", {7'h00, exp_req()}, {7'h00, irq_request});
    end
    wr(8'h00, 8'h00);
    ctl = 0;
    // Timer overflow sets its flag with every control register enable off
    @(posedge ref_clk);
    timer_zero_ovf <= 1'h1;
    @(posedge ref_clk);
    timer_zero_ovf <= 1'h0;
    ctl = 4;
    rchk("timer_flag", 8'h00, ctl_exp());
    // Wrong edge leaves the pin flag clear, right edge sets it
    for (int s = 0; s < 2; s++) begin
      ext_pin_edge_select <= 1'(s);
      ext_pin <= 1'(s);
      repeat (6) @(posedge ref_clk);
      wr(8'h00, 8'h00);
      ctl = 0;
      ext_pin <= !1'(s);
      repeat (6) @(posedge ref_clk);
      rchk("wrong_edge", 8'h00, ctl_exp());
      ext_pin <= 1'(s);
      repeat (6) @(posedge ref_clk);
      ctl = 2;
      rchk("pin_flag", 8'h00, ctl_exp());
    end
    // Timer request taken slowly then promptly, then returned from
    for (int k = 0; k < 2; k++) begin
      slow <= (k == 0);
      take_en <= 1'h1;
      wr(8'h00, 8'h00);
      wr(8'h00, 8'ha4);
      #1;
      n = 0;
      while (vector_load !== 1'h1 && n < 20) begin
        @(posedge ref_clk);
        #1;
        n++;
      end
      cmp("vector_load", 8'h01, {7'h00, vector_load});
      cmp("vector", 8'h01, {7'h00, vector_addr === 15'h0004});
      take_en <= 1'h0;
      ctl = 8'h24;
      rchk("global_cleared", 8'h00, ctl_exp());
      rchk("in_handler", 8'h05, 8'h01);
      rchk("status", 8'h03, 8'h01);
      cmp("masked_event", 8'h00, {7'h00, event_irq});
      wr(8'h04, 8'h01);
      #1;
      cmp("event", 8'h01, {7'h00, event_irq});
      wr(8'h03, 8'h01);
      #1;
      cmp("event_cleared", 8'h00, {7'h00, event_irq});
      ret_cmd <= 1'h1;
      @(posedge ref_clk);
      ret_cmd <= 1'h0;
      ctl = 8'ha4;
      rchk("global_set", 8'h00, ctl_exp());
      cmp("request_again", 8'h01, {7'h00, irq_request});
      rchk("status_ret", 8'h03, 8'h02);
      rchk("handler_left", 8'h05, 8'h00);
      wr(8'h03, 8'h07);
      wr(8'h04, 8'h00);
      wr(8'h00, 8'h00);
      ctl = 0;
    end
    // An accept with nothing pending only marks the stray event
    @(posedge ref_clk);
    stray <= 1'h1;
    ext_pin <= 1'h0;
    @(posedge ref_clk);
    stray <= 1'h0;
    rchk("stray_accept", 8'h03, 8'h04);
    // A reset in mid-run clears everything firmware had set
    wr(8'h01, 8'hff);
    wr(8'h02, 8'hff);
    wr(8'h00, 8'hfe);
    rst <= 1'h1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'h0;
    ctl = 0;
    rchk("control_reset", 8'h00, ctl_exp());
    rchk("enable_one_reset", 8'h01, 8'h00);
    rchk("enable_two_reset", 8'h02, 8'h00);
    stop_test();
  end
endmodule
